// File: rtl/pur_cal.sv
// Combinational BCD clock and calendar advance by one hundredth
`default_nettype none
module pur_cal (
   input wire logic tick,
   input wire pur_pkg::pur_regs_t cur,
   output pur_pkg::pur_regs_t nxt
);
   logic [8:0] hund, sec, mins, hr24, hr12, wday, date, mon, year;
   logic [7:0] dim;
   logic leap;
   logic hr_c;
   // Field steps first, then the carry chain picks which ones land
   always_comb begin
      hund = pur_pkg::pur_bcd_step(cur[0], 8'h00, 8'h99);
      sec = pur_pkg::pur_bcd_step(cur[1], 8'h00, 8'h59);
      mins = pur_pkg::pur_bcd_step(cur[2], 8'h00, 8'h59);
      hr24 = pur_pkg::pur_bcd_step({2'b00, cur[3][5:0]}, 8'h00, 8'h23);
      hr12 = pur_pkg::pur_bcd_step({3'b000, cur[3][4:0]}, 8'h01, 8'h12);
      wday = pur_pkg::pur_bcd_step({5'b00000, cur[4][2:0]}, 8'h01, 8'h07);
      // Every fourth year; year 00 counts as leap, right for 2000 only
      leap = cur[7][4] ? (cur[7][3:0] == 4'h2 || cur[7][3:0] == 4'h6)
                       : (cur[7][3:0] == 4'h0 || cur[7][3:0] == 4'h4 || cur[7][3:0] == 4'h8);
      case (cur[6])
         8'h02: dim = leap ? 8'h29 : 8'h28;
         8'h04, 8'h06, 8'h09, 8'h11: dim = 8'h30;
         default: dim = 8'h31;
      endcase
      date = pur_pkg::pur_bcd_step(cur[5], 8'h01, dim);
      mon = pur_pkg::pur_bcd_step(cur[6], 8'h01, 8'h12);
      year = pur_pkg::pur_bcd_step(cur[7], 8'h00, 8'h99);
      hr_c = 1'b0;
      nxt = cur;
      if (tick) begin
         nxt[0] = hund[7:0];
         if (hund[8]) begin
            nxt[1] = sec[7:0];
            if (sec[8]) begin
               nxt[2] = mins[7:0];
               if (mins[8]) begin
                  if (cur[3][pur_pkg::HR_MODE_BIT]) begin
                     // 11 to 12 flips the meridiem; only 11 PM rolls the day
                     nxt[3] = {cur[3][7:6], cur[3][5] ^ (cur[3][4:0] == 5'h11), hr12[4:0]};
                     hr_c = cur[3][pur_pkg::HR_PM_BIT] && cur[3][4:0] == 5'h11;
                  end else begin
                     nxt[3] = {cur[3][7:6], hr24[5:0]};
                     hr_c = hr24[8];
                  end
                  if (hr_c) begin
                     nxt[4] = {cur[4][7:3], wday[2:0]};
                     nxt[5] = date[7:0];
                     if (date[8]) begin
                        nxt[6] = mon[7:0];
                        if (mon[8]) begin
                           nxt[7] = year[7:0];
                        end
                     end
                  end
               end
            end
         end
      end
   end
endmodule // pur_cal
`default_nettype wire

// File: rtl/pur_fifo.sv
// Parameterised flip-flop FIFO with valid/ready on both sides
`default_nettype none
module pur_fifo #(
   parameter int WIDTH = 11,
   parameter int DEPTH = 16
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic flush,
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } pur_fifo_s;
   pur_fifo_s s;
   pur_fifo_s next_s;
   logic push;
   logic pop;
   // Pointers wrap by width, so depth must be a power of two
   assign in_ready = s.cnt != (AW + 1)'(DEPTH);
   assign out_valid = s.cnt != '0;
   assign out_data = s.mem[s.rp];
   // Next state; flush wins over a simultaneous push
   always_comb begin
      next_s = s;
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      if (push) begin
         next_s.mem[s.wp] = in_data;
         next_s.wp = s.wp + 1'b1;
      end
      if (pop) begin
         next_s.rp = s.rp + 1'b1;
      end
      next_s.cnt = s.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
      if (flush) begin
         next_s.wp = '0;
         next_s.rp = '0;
         next_s.cnt = '0;
      end
   end
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
endmodule // pur_fifo
`default_nettype wire

// File: rtl/pur_pkg.sv
// Shared constants, types and BCD helper for the pattern-unlocked timekeeper
`default_nettype none
package pur_pkg;
   // Unlock key, first byte in the low bits, each byte sent LSB first
   localparam logic [63:0] KEY = 64'h5ca3_3ac5_5ca3_3ac5;
   localparam logic [5:0] LAST_BIT = 6'h3f;
   localparam int FIFO_W = 11;
   localparam int FIFO_D = 16;
   // Register indices
   localparam logic [2:0] REG_HUND = 3'h0;
   localparam logic [2:0] REG_HOUR = 3'h3;
   localparam logic [2:0] REG_DAY = 3'h4;
   localparam logic [2:0] REG_YEAR = 3'h7;
   // Field positions
   localparam int HR_MODE_BIT = 7;
   localparam int HR_PM_BIT = 5;
   localparam int DAY_RST_BIT = 4;
   localparam int DAY_OSC_BIT = 5;
   // Synchronised pin positions
   localparam int PIN_CE = 0;
   localparam int PIN_OE = 1;
   localparam int PIN_WE = 2;
   localparam int PIN_D = 3;
   localparam int PIN_ABORT = 4;
   localparam int PIN_PF = 5;
   localparam int PIN_ROM = 6;
   localparam int PIN_XTAL = 7;
   // Crystal rate and hundredths rate for the phase accumulator
   localparam logic [15:0] XTAL_HZ = 16'h8000;
   localparam logic [15:0] TICK_HZ = 16'h0064;
   typedef logic [7:0][7:0] pur_regs_t;
   // Writable bits per register, year first
   localparam pur_regs_t REG_MASK = {8'hff, 8'h1f, 8'h3f, 8'h37, 8'hbf, 8'h7f, 8'h7f, 8'hff};
   localparam pur_regs_t REG_RESET = {8'h00, 8'h01, 8'h01, 8'h21, 8'h00, 8'h00, 8'h00, 8'h00};
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_MATCH = 2'b01,
      ST_DEAD = 2'b10,
      ST_XFER = 2'b11
   } pur_state_e;
   typedef enum logic [1:0] {
      EV_NONE = 2'b00,
      EV_WR = 2'b01,
      EV_RD = 2'b10
   } pur_event_e;
   // BCD step: returns {carry, value}; values above hi also wrap to lo
   function automatic logic [8:0] pur_bcd_step(input logic [7:0] v, input logic [7:0] lo,
                                               input logic [7:0] hi);
      if (v >= hi) begin
         pur_bcd_step = {1'b1, lo};
      end else if (v[3:0] == 4'h9) begin
         pur_bcd_step = {1'b0, v[7:4] + 4'h1, 4'h0};
      end else begin
         pur_bcd_step = {1'b0, v[7:4], v[3:0] + 4'h1};
      end
   endfunction
endpackage
`default_nettype wire

// File: rtl/pur_top.sv
// Timekeeper hidden behind a memory chip enable, unlocked by a serial key
`default_nettype none
module pur_top (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic chip_enable_in_n,
   input wire logic out_enable_n,
   input wire logic write_enable_n,
   input wire logic data_in,
   output logic data_out,
   output logic data_out_oe,
   output logic memory_enable_out_n,
   input wire logic abort_n,
   input wire logic power_fail,
   input wire logic rom_mode,
   input wire logic xtal_in
);
   typedef struct packed {
      logic [7:0] s1;
      logic [7:0] s2;
      logic [7:0] s3;
      logic [7:0] f;
      logic ce_d;
      logic xtal_d;
      pur_pkg::pur_state_e st;
      logic [5:0] ptr;
      logic [5:0] idx;
      logic saw_wr;
      logic saw_rd;
      logic wbit;
      pur_pkg::pur_event_e ev;
      logic ev_bit;
      logic [63:0] snap;
      logic [7:0] asmb;
      logic wany;
      logic commit;
      logic q;
      logic q_oe;
      logic [15:0] acc;
      pur_pkg::pur_regs_t regs;
   } pur_top_s;
   pur_top_s s;
   pur_top_s next_s;
   logic pf, rom, abort, go, go_wr, go_rd, tick, push_req, stall, wany_n, xbit, flush;
   logic f_in_ready, f_out_valid, f_out_ready;
   logic [7:0] asm_n;
   logic [15:0] sum;
   logic [10:0] f_out_data;
   pur_pkg::pur_regs_t cal_nxt;

   pur_fifo #(
      .WIDTH(pur_pkg::FIFO_W),
      .DEPTH(pur_pkg::FIFO_D)
   ) u_fifo (
      .core_clk(core_clk),
      .rstn(rstn),
      .flush(flush),
      .in_valid(push_req),
      .in_data({s.idx[5:3], asm_n}),
      .in_ready(f_in_ready),
      .out_valid(f_out_valid),
      .out_data(f_out_data),
      .out_ready(f_out_ready)
   );

   pur_cal u_cal (
      .tick(tick),
      .cur(s.regs),
      .nxt(cal_nxt)
   );

   // Filtered pin levels; the bus strobes are async to core_clk
   assign pf = s.f[pur_pkg::PIN_PF];
   assign rom = s.f[pur_pkg::PIN_ROM];

   assign memory_enable_out_n = pf ? !rom : ((s.st == pur_pkg::ST_XFER) ? 1'b1 : chip_enable_in_n);
   assign data_out = s.q;
   assign data_out_oe = s.q_oe;
   // Drain stalls on a tick so a count and a host write never collide
   assign f_out_ready = s.commit && !tick;

   // Control terms that the next-state process and the checks share
   always_comb begin
      abort = pf || (!s.regs[pur_pkg::REG_DAY][pur_pkg::DAY_RST_BIT] && !s.f[pur_pkg::PIN_ABORT]);
      xbit = (s.ev == pur_pkg::EV_WR) ? s.ev_bit : s.snap[s.idx];
      wany_n = s.wany || (s.ev == pur_pkg::EV_WR);
      asm_n = s.asmb;
      asm_n[s.idx[2:0]] = xbit;
      push_req = (s.st == pur_pkg::ST_XFER) && (s.ev != pur_pkg::EV_NONE) && (s.idx[2:0] == 3'h7)
                 && wany_n && !abort;
      stall = push_req && !f_in_ready;
      go = (s.ev != pur_pkg::EV_NONE) && !stall && !abort;
      go_wr = go && (s.ev == pur_pkg::EV_WR);
      go_rd = go && (s.ev == pur_pkg::EV_RD);
      flush = abort && (s.st == pur_pkg::ST_XFER);
      sum = s.acc + pur_pkg::TICK_HZ;
      tick = s.f[pur_pkg::PIN_XTAL] && !s.xtal_d && !s.regs[pur_pkg::REG_DAY][pur_pkg::DAY_OSC_BIT]
             && (sum >= pur_pkg::XTAL_HZ);
   end

   // Next state of the whole block
   always_comb begin
      next_s = s;
      // Three-stage sync; a level moves once stages two and three agree
      next_s.s1 = {xtal_in, rom_mode, power_fail, abort_n, data_in, write_enable_n, out_enable_n,
                   chip_enable_in_n};
      next_s.s2 = s.s1;
      next_s.s3 = s.s2;
      next_s.f = (s.f & (s.s2 ^ s.s3)) | (s.s2 & ~(s.s2 ^ s.s3));
      next_s.ce_d = s.f[pur_pkg::PIN_CE];
      next_s.xtal_d = s.f[pur_pkg::PIN_XTAL];
      if (s.f[pur_pkg::PIN_XTAL] && !s.xtal_d && !s.regs[pur_pkg::REG_DAY][pur_pkg::DAY_OSC_BIT]) begin
         next_s.acc = tick ? sum - pur_pkg::XTAL_HZ : sum;
      end
      if (!s.f[pur_pkg::PIN_CE]) begin
         if (!s.f[pur_pkg::PIN_WE]) begin
            next_s.saw_wr = 1'b1;
            next_s.wbit = s.f[pur_pkg::PIN_D];
         end
         if (!s.f[pur_pkg::PIN_OE]) begin
            next_s.saw_rd = 1'b1;
         end
      end
      if (go) begin
         next_s.ev = pur_pkg::EV_NONE;
      end
      // A cycle is judged when chip enable rises; write beats read
      if (s.f[pur_pkg::PIN_CE] && !s.ce_d) begin
         next_s.ev = s.saw_wr ? pur_pkg::EV_WR : (s.saw_rd ? pur_pkg::EV_RD : pur_pkg::EV_NONE);
         next_s.ev_bit = s.wbit;
         next_s.saw_wr = 1'b0;
         next_s.saw_rd = 1'b0;
      end
      case (s.st)
         pur_pkg::ST_IDLE, pur_pkg::ST_DEAD: begin
            if (go_rd) begin
               next_s.st = pur_pkg::ST_MATCH;
               next_s.ptr = 6'h00;
            end
         end
         pur_pkg::ST_MATCH: begin
            if (go_rd) begin
               next_s.ptr = 6'h00;
            end else if (go_wr) begin
               if (s.ev_bit == pur_pkg::KEY[s.ptr]) begin
                  next_s.ptr = s.ptr + 6'h01;
                  if (s.ptr == pur_pkg::LAST_BIT) begin
                     next_s.st = pur_pkg::ST_XFER;
                     next_s.idx = 6'h00;
                     next_s.snap = s.regs;
                     next_s.wany = 1'b0;
                  end
               end else begin
                  next_s.st = pur_pkg::ST_DEAD;
               end
            end
         end
         pur_pkg::ST_XFER: begin
            if (go) begin
               next_s.asmb = asm_n;
               next_s.wany = (s.idx[2:0] == 3'h7) ? 1'b0 : wany_n;
               next_s.idx = s.idx + 6'h01;
               if (s.idx == pur_pkg::LAST_BIT) begin
                  next_s.st = pur_pkg::ST_IDLE;
               end
            end
         end
         default: begin
            next_s.st = pur_pkg::ST_IDLE;
         end
      endcase
      // Read data waits on the bit index so it stands before the strobe
      next_s.q = s.snap[next_s.idx];
      next_s.q_oe = (s.st == pur_pkg::ST_XFER) && !s.f[pur_pkg::PIN_CE] && !s.f[pur_pkg::PIN_OE]
                    && s.f[pur_pkg::PIN_WE] && !abort;
      // Commit after the whole stream; setting wins over the clear
      if (s.commit && !f_out_valid) begin
         next_s.commit = 1'b0;
      end
      if (go && s.st == pur_pkg::ST_XFER && s.idx == pur_pkg::LAST_BIT) begin
         next_s.commit = 1'b1;
      end
      if (abort) begin
         next_s.st = pur_pkg::ST_IDLE;
         next_s.ev = pur_pkg::EV_NONE;
         next_s.wany = 1'b0;
         next_s.q_oe = 1'b0;
      end
      if (tick) begin
         next_s.regs = cal_nxt;
      end else if (f_out_valid && f_out_ready) begin
         next_s.regs[f_out_data[10:8]] = f_out_data[7:0] & pur_pkg::REG_MASK[f_out_data[10:8]];
      end
   end

   // Single state register
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         // Sync stages start at the pins' idle levels so no false power fail or crystal edge follows reset
         s <= '{s1: 8'h1f, s2: 8'h1f, s3: 8'h1f, f: 8'h1f, ce_d: 1'b1, xtal_d: 1'b0, st: pur_pkg::ST_IDLE,
                ptr: 6'h00, idx: 6'h00, saw_wr: 1'b0, saw_rd: 1'b0, wbit: 1'b0, ev: pur_pkg::EV_NONE,
                ev_bit: 1'b0, snap: 64'h0, asmb: 8'h00, wany: 1'b0, commit: 1'b0, q: 1'b0, q_oe: 1'b0,
                acc: 16'h0000, regs: pur_pkg::REG_RESET};
      end else begin
         s <= next_s;
      end
   end

   // Checks, all on the core clock
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);

   a_pass_through: assert property (!pf && s.st != pur_pkg::ST_XFER |->
                                    memory_enable_out_n == chip_enable_in_n)
      else $error("memory enable does not follow chip enable");
   a_xfer_hold_off: assert property (!pf && s.st == pur_pkg::ST_XFER |-> memory_enable_out_n)
      else $error("memory enabled during transfer");
   a_ram_protect: assert property (pf && !rom |-> memory_enable_out_n)
      else $error("RAM not protected in power fail");
   a_rom_pf_low: assert property (pf && rom |-> !memory_enable_out_n)
      else $error("ROM enable not low in power fail");
   a_read_rearm: assert property (go_rd && s.st != pur_pkg::ST_XFER |=>
                                  s.st == pur_pkg::ST_MATCH && s.ptr == 6'h00)
      else $error("read did not rearm the key pointer");
   a_key_mismatch: assert property (go_wr && s.st == pur_pkg::ST_MATCH &&
                                    s.ev_bit != pur_pkg::KEY[s.ptr] |=> s.st == pur_pkg::ST_DEAD)
      else $error("key mismatch not locked out");
   a_dead_ignores: assert property (s.st == pur_pkg::ST_DEAD && !go_rd |=>
                                    s.st != pur_pkg::ST_XFER && $stable(s.ptr))
      else $error("locked-out sequence moved");
   a_key_unlock: assert property (go_wr && s.st == pur_pkg::ST_MATCH && s.ptr == pur_pkg::LAST_BIT &&
                                  s.ev_bit == pur_pkg::KEY[pur_pkg::LAST_BIT] |=> s.st == pur_pkg::ST_XFER
                                  && s.idx == 6'h00 && s.snap == $past(s.regs))
      else $error("full key did not unlock");
   a_pf_abort: assert property (pf |=> s.st == pur_pkg::ST_IDLE && !s.q_oe)
      else $error("power fail did not abort");
   a_regs_quiet: assert property (!tick && !(f_out_valid && f_out_ready) |=> $stable(s.regs))
      else $error("registers changed without cause");
   a_zero_bits: assert property ((s.regs[1][7] | s.regs[3][6] | s.regs[4][7] | s.regs[5][7:6]
                                  | s.regs[6][7:5]) == 1'b0)
      else $error("unused bit set");
   a_osc_stop: assert property (s.regs[pur_pkg::REG_DAY][pur_pkg::DAY_OSC_BIT] |-> !tick)
      else $error("tick while oscillator stopped");
   a_read_drive: assert property (s.q_oe |-> s.st == pur_pkg::ST_XFER)
      else $error("data driven outside transfer");

   c_unlock: cover property (s.st == pur_pkg::ST_MATCH ##1 s.st == pur_pkg::ST_XFER);
   c_commit: cover property (s.commit && f_out_valid && f_out_ready);
   c_read_bit: cover property (s.q_oe && s.q);
   c_lockout: cover property (s.st == pur_pkg::ST_DEAD);
endmodule // pur_top
`default_nettype wire

// File: verification/pur_host.sv
// Host memory bus model: drives chip enable, strobes and data, watches the block
`default_nettype none
module pur_host (
   input wire logic core_clk,
   input wire logic data_out,
   input wire logic data_out_oe,
   input wire logic memory_enable_out_n,
   output logic chip_enable_in_n,
   output logic out_enable_n,
   output logic write_enable_n,
   output logic data_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] key_byte [4] = '{8'hc5, 8'h3a, 8'ha3, 8'h5c};
   logic q_seen, oe_seen, meo_seen;
   // Bus idle at time zero
   initial begin
      chip_enable_in_n = 1'b1;
      out_enable_n = 1'b1;
      write_enable_n = 1'b1;
      data_in = 1'b0;
   end
   // One bus cycle; strobes held 8 clocks so the 3-stage pin filter sees them
   task automatic cycle(input logic wr, input logic bit_in, input logic ce_on);
      @(negedge core_clk);
      chip_enable_in_n <= ~ce_on;
      out_enable_n <= wr;
      write_enable_n <= ~wr;
      data_in <= wr ? bit_in : ~bit_in;
      repeat (8) @(negedge core_clk);
      q_seen = data_out;
      oe_seen = data_out_oe;
      meo_seen = memory_enable_out_n;
      chip_enable_in_n <= 1'b1;
      out_enable_n <= 1'b1;
      write_enable_n <= 1'b1;
      data_in <= ~data_in; // Released line must not keep its old level
      repeat (8) @(negedge core_clk);
   endtask
   // arming read, then key bits LSB first; mix adds cycles without chip enable
   task automatic unlock(input int bad_at, input logic mix);
      cycle(1'b0, 1'b0, 1'b1);
      for (int i = 0; i < 64; i++) begin
         cycle(1'b1, key_byte[(i / 8) % 4][i % 8] ^ (i == bad_at), 1'b1);
         if (mix) cycle(1'(i % 2), 1'b0, 1'b0);
      end
   endtask
endmodule // pur_host
`default_nettype wire

// File: verification/tb_top.sv
// Self-checking bench for the serial-key timekeeper
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic abort_n = 1'b1;
   logic power_fail = 1'b0;
   logic rom_mode = 1'b0;
   logic xtal_in = 1'b0;
   logic ce_n, oe_n, we_n, d_in, q, q_oe, meo_n;
   int bad_count = 0;
   int compares = 0;
   logic [7:0] model_regs [8];
   logic [7:0] vals [8];

   pur_top pur_top_inst (.core_clk(core_clk), .rstn(rstn), .chip_enable_in_n(ce_n), .out_enable_n(oe_n),
      .write_enable_n(we_n), .data_in(d_in), .data_out(q), .data_out_oe(q_oe), .memory_enable_out_n(meo_n),
      .abort_n(abort_n), .power_fail(power_fail), .rom_mode(rom_mode), .xtal_in(xtal_in));
   pur_host pur_host_inst (.core_clk(core_clk), .data_out(q), .data_out_oe(q_oe), .memory_enable_out_n(meo_n),
      .chip_enable_in_n(ce_n), .out_enable_n(oe_n), .write_enable_n(we_n), .data_in(d_in));

   // 50 MHz clock
   initial begin
      forever #10 core_clk = ~core_clk;
   end

   task automatic complete_run();
      if (bad_count == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         $display("[ERR] %s expected %h seen %h", what, exp, got);
         bad_count++;
      end
   endtask

   function automatic logic [7:0] bcd(input int v);
      bcd = 8'((v / 10) * 16 + v % 10);
   endfunction

   // Unlock then move whole registers; stop_at cuts a write short to leave it pending
   task automatic session(input logic wr, input int stop_at, input logic mix);
      logic [7:0] got;
      pur_host_inst.unlock(-1, mix);
      for (int i = 0; i < 64 && i != stop_at; i++) begin
         pur_host_inst.cycle(wr, vals[i / 8][i % 8], 1'b1);
         got[i % 8] = pur_host_inst.q_seen;
         check("meo_n_xfer", 8'h01, {7'h0, pur_host_inst.meo_seen});
         if (!wr) check("q_oe", 8'h01, {7'h0, pur_host_inst.oe_seen});
         if (!wr && i % 8 == 7) check("reg_read", model_regs[i / 8], got);
      end
      repeat (20) @(negedge core_clk);
      if (wr && stop_at < 0) for (int r = 0; r < 8; r++) model_regs[r] = vals[r] & pur_pkg::REG_MASK[r];
   endtask

   // Watchdog sized well past the planned sessions
   initial begin
      repeat (75000) @(posedge core_clk);
      bad_count++;
      complete_run();
   end

   initial begin
      void'($urandom(19));
      for (int r = 0; r < 8; r++) model_regs[r] = pur_pkg::REG_RESET[r];
      repeat (6) @(negedge core_clk);
      rstn <= 1'b1;
      repeat (6) @(negedge core_clk);
      session(1'b0, -1, 1'b0);
      // Random BCD times with unused bits set, which must read back as zero
      vals = '{bcd($urandom % 100), bcd($urandom % 60) | 8'h80, bcd($urandom % 60) | 8'h80,
         bcd($urandom % 24) | 8'h40, bcd(1 + $urandom % 7) | 8'h28, bcd(1 + $urandom % 28) | 8'hc0,
         bcd(1 + $urandom % 12) | 8'he0, bcd($urandom % 100)};
      session(1'b1, -1, 1'b0);
      session(1'b0, -1, 1'b0);
      // Wrong key bit locks out, memory stays reachable
      pur_host_inst.unlock(5, 1'b0);
      pur_host_inst.cycle(1'b1, 1'b0, 1'b1);
      check("meo_n_locked", 8'h00, {7'h0, pur_host_inst.meo_seen});
      // Read in mid-key must restart the pointer
      pur_host_inst.cycle(1'b0, 1'b0, 1'b1);
      for (int i = 0; i < 20; i++) pur_host_inst.cycle(1'b1, pur_host_inst.key_byte[i / 8][i % 8], 1'b1);
      session(1'b0, -1, 1'b0);
      session(1'b0, -1, 1'b1);
      // Abort pin honoured while day bit 4 is zero; pending byte differs from held value
      vals[0] = model_regs[0] ^ 8'h01;
      session(1'b1, 10, 1'b0);
      abort_n <= 1'b0;
      repeat (8) @(negedge core_clk);
      abort_n <= 1'b1;
      repeat (8) @(negedge core_clk);
      session(1'b0, -1, 1'b0);
      // Power fail in mid-transfer, RAM then ROM mode
      session(1'b1, 10, 1'b0);
      power_fail <= 1'b1;
      repeat (8) @(negedge core_clk);
      pur_host_inst.cycle(1'b1, 1'b0, 1'b1);
      check("meo_n_pf_ram", 8'h01, {7'h0, pur_host_inst.meo_seen});
      rom_mode <= 1'b1;
      repeat (8) @(negedge core_clk);
      pur_host_inst.cycle(1'b1, 1'b0, 1'b1);
      check("meo_n_pf_rom", 8'h00, {7'h0, pur_host_inst.meo_seen});
      power_fail <= 1'b0;
      rom_mode <= 1'b0;
      repeat (8) @(negedge core_clk);
      session(1'b0, -1, 1'b0);
      // Oscillator on, last hundredth of 28 Feb in a non-leap year
      vals = '{8'h99, 8'h59, 8'h59, 8'h23, 8'h07, 8'h28, 8'h02, 8'h01};
      session(1'b1, -1, 1'b0);
      // 32768 Hz over 100 gives the tick on the 328th crystal edge; crystal sped up to save run time
      repeat (328) begin
         xtal_in <= 1'b1;
         repeat (3) @(negedge core_clk);
         xtal_in <= 1'b0;
         repeat (3) @(negedge core_clk);
      end
      model_regs = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h03, 8'h01};
      session(1'b0, -1, 1'b0);
      complete_run();
   end
endmodule // tb_top
`default_nettype wire
